// File: logic/psm_pkg.sv
// shared constants for the pipelined synchronous word memory
// assumes both ends run on one clock and one asynchronous reset
package psm_pkg;
	localparam int ADDR_W      = 16;
	localparam int DATA_W      = 32;
	localparam int LANES       = 4;
	localparam int LANE_W      = 8;
	localparam int DEPTH       = 65536;
	// start-up figures, in clock cycles
	localparam int INIT_HOLD_CYC  = 10;
	localparam int CLK_PRE_CYC    = 2;
	localparam int START_WAIT_CYC = 128;
	localparam logic [LANES-1:0] LANES_OFF = 4'hf;
endpackage

// File: logic/psm_link_if.sv
// memory link between host end and memory end
// assumes a common clock; both parties sample on its rising edge
`timescale 1ns/1ps
interface psm_link_if;
	logic [psm_pkg::ADDR_W-1:0] addr;
	logic                       rd_n;
	logic                       wr_n;
	logic [psm_pkg::LANES-1:0]  lane_en_n;
	logic [psm_pkg::DATA_W-1:0] wdata;
	logic [psm_pkg::DATA_W-1:0] rdata;
	logic                       init_n;

	modport host (
		output addr, rd_n, wr_n, lane_en_n, wdata, init_n,
		input  rdata
	);
	modport mem (
		input  addr, rd_n, wr_n, lane_en_n, wdata, init_n,
		output rdata
	);
endinterface

// File: logic/psm_memory.sv
// memory end: 64k x 32 array, pipelined read, late write
// assumes the host keeps strobes legal and waits out start-up
`timescale 1ns/1ps
module psm_memory #(
	parameter int ADDR_W = psm_pkg::ADDR_W,
	parameter int DATA_W = psm_pkg::DATA_W,
	parameter int DEPTH  = psm_pkg::DEPTH
) (
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_arst_n,
	// link to the host
	psm_link_if.mem   link
);
	localparam int LANES  = psm_pkg::LANES;
	localparam int LANE_W = psm_pkg::LANE_W;

	// word read out of the lane arrays below
	wire  [DATA_W-1:0] rd_word;

	logic              wr_pend;
	logic [ADDR_W-1:0] wr_addr;
	logic              rd_pend;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rdata;

	////////////////////////////////////////////////////////////////////////
	// strobe decode; both low treated as no operation
	wire cmd_rd = !link.rd_n && link.wr_n;
	wire cmd_wr = link.rd_n && !link.wr_n;

	////////////////////////////////////////////////////////////////////////
	// command capture stage
	// init reset clears only the pipeline
	// one command per edge, no gaps
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			wr_addr <= '0;
			rd_addr <= '0;
		end else if (!link.init_n) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
		end else begin
			wr_pend <= cmd_wr;
			rd_pend <= cmd_rd;
			if (cmd_wr)
				wr_addr <= link.addr;
			if (cmd_rd)
				rd_addr <= link.addr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// late write: data and lanes sampled the edge after the command
	// arrays have no reset, so init leaves contents alone
	// lanes and data only looked at on the data edge of a write
	// one array per lane, so each array has a single writing process
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		// one byte lane of every word
		logic [LANE_W-1:0] lane_store [DEPTH];
		// lane g written when its enable is low
		always_ff @(posedge i_clock) begin
			if (wr_pend && link.init_n && !link.lane_en_n[g])
				lane_store[wr_addr] <= link.wdata[g*LANE_W +: LANE_W];
		end
		// lane g of the word being read
		assign rd_word[g*LANE_W +: LANE_W] = lane_store[rd_addr];
	end

	////////////////////////////////////////////////////////////////////////
	// array read at the edge after the strobe edge; a write data edge
	// never meets a read edge, so no forwarding is needed
	// output register holds last read word through other cycles
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n)
			rdata <= '0;
		else if (rd_pend && link.init_n)
			rdata <= rd_word;
	end

	assign link.rdata = rdata;
endmodule

// File: logic/psm_host.sv
// host end: turns user requests into memory link cycles
// assumes one clock shared with the memory end
`timescale 1ns/1ps
module psm_host #(
	parameter int ADDR_W = psm_pkg::ADDR_W,
	parameter int DATA_W = psm_pkg::DATA_W,
	parameter int LANES  = psm_pkg::LANES
) (
	// clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_arst_n,
	// user requests
	input  wire logic              i_req,
	input  wire logic              i_we,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [LANES-1:0]  i_lane_en,
	input  wire logic [DATA_W-1:0] i_wdata,
	// user answers
	output logic                   o_ready,
	output logic                   o_rvalid,
	output logic [DATA_W-1:0]      o_rdata,
	// link to the memory
	psm_link_if.host               link
);
	typedef enum logic [1:0] {
		PSM_PRE, PSM_INIT, PSM_WAIT, PSM_RUN
	} psm_state_t;
	psm_state_t state;
	logic [7:0] cnt;
	logic       init_n, rd_n, wr_n, ready;
	logic [ADDR_W-1:0] addr;
	logic [LANES-1:0]  lane_en_n;
	logic [DATA_W-1:0] wdata, pend_data;
	logic [LANES-1:0]  pend_lanes;
	logic              wr_d, rd_d1, rd_d2, rvalid;
	logic [DATA_W-1:0] rdata;

	////////////////////////////////////////////////////////////////////////
	// start-up: clock first, init held, wait before access
	wire take   = ready && i_req;
	wire cnt_hit_pre  = cnt == 8'(psm_pkg::CLK_PRE_CYC - 1);
	wire cnt_hit_init = cnt == 8'(psm_pkg::INIT_HOLD_CYC - 1);
	wire cnt_hit_wait = cnt == 8'(psm_pkg::START_WAIT_CYC - 1);

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state  <= PSM_PRE;
			cnt    <= '0;
			init_n <= 1'b1;
			ready  <= 1'b0;
		end else begin
			cnt <= cnt + 8'h01;
			unique case (state)
				PSM_PRE: if (cnt_hit_pre) begin
					state  <= PSM_INIT;
					cnt    <= '0;
					init_n <= 1'b0;
				end
				PSM_INIT: if (cnt_hit_init) begin
					state  <= PSM_WAIT;
					cnt    <= '0;
					init_n <= 1'b1;
				end
				PSM_WAIT: if (cnt_hit_wait) begin
					state <= PSM_RUN;
					ready <= 1'b1;
				end
				PSM_RUN: cnt <= cnt;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command cycle; never both strobes low
	// write data and lanes follow one cycle later
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			addr <= '0;
			lane_en_n <= psm_pkg::LANES_OFF;
			wdata <= '0;
			pend_data <= '0;
			pend_lanes <= '0;
			wr_d <= 1'b0;
		end else begin
			rd_n <= !(take && !i_we);
			wr_n <= !(take && i_we);
			if (take)
				addr <= i_addr;
			wr_d <= take && i_we;
			pend_data <= i_wdata;
			pend_lanes <= i_lane_en;
			lane_en_n <= wr_d ? ~pend_lanes : psm_pkg::LANES_OFF;
			wdata <= wr_d ? pend_data : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read return: data on link two edges after the strobe edge
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rd_d1 <= 1'b0;
			rd_d2 <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
		end else begin
			rd_d1 <= !rd_n;
			rd_d2 <= rd_d1;
			rvalid <= rd_d2;
			if (rd_d2)
				rdata <= link.rdata;
		end
	end

	assign o_ready  = ready;
	assign o_rvalid = rvalid;
	assign o_rdata  = rdata;
	assign link.init_n    = init_n;
	assign link.rd_n      = rd_n;
	assign link.wr_n      = wr_n;
	assign link.addr      = addr;
	assign link.lane_en_n = lane_en_n;
	assign link.wdata     = wdata;
endmodule

// File: verif/psm_monitor.sv
// link checker: strobe legality, start-up order, read pipeline
// assumes one clock; watches the link beside the two ends
`timescale 1ns/1ps
module psm_monitor (
	// clock and reset
	input wire logic                       i_clock,
	input wire logic                       i_arst_n,
	// link signals watched
	input wire logic                       i_rd_n,
	input wire logic                       i_wr_n,
	input wire logic [psm_pkg::DATA_W-1:0] i_rdata,
	input wire logic                       i_init_n
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	logic [7:0] up;
	logic [7:0] w;
	wire        cmd = !i_rd_n || !i_wr_n;
	////////////////////////////////////////////////////////////////////////
	// saturating counts: since reset release and since init ended
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			up <= 8'h00;
			w  <= 8'h00;
		end else begin
			up <= (up == 8'hff) ? up : up + 8'h01;
			w  <= !i_init_n ? 8'h00 : (w == 8'hff) ? w : w + 8'h01;
		end
	end
	sequence s_low5;
		!i_init_n [*5];
	endsequence
	////////////////////////////////////////////////////////////////////////
	a_one_strobe: assert property (i_rd_n || i_wr_n)
		else $error("both strobes low");
	a_init_long: assert property ($fell(i_init_n) |->
		s_low5 ##1 s_low5)
		else $error("init pulse too short");
	a_init_ends: assert property ($fell(i_init_n) |->
		##[10:40] i_init_n)
		else $error("init pulse never ends");
	a_clock_first: assert property ($fell(i_init_n) |->
		up >= 8'(psm_pkg::CLK_PRE_CYC))
		else $error("init before two clocks");
	a_start_wait: assert property (cmd |->
		w >= 8'(psm_pkg::START_WAIT_CYC))
		else $error("access before start-up wait");
	a_idle_init: assert property (!i_init_n |-> i_rd_n && i_wr_n)
		else $error("access during init");
	a_wait_quiet: assert property ($rose(i_init_n) |-> !cmd [*8])
		else $error("access right after init");
	a_rdata_hold: assert property (!$stable(i_rdata) |->
		!$past(i_rd_n, 2))
		else $error("read data moved without a read");
endmodule

// File: verif/testbench.sv
// bench: host end and memory end joined by the link
// assumes 250 MHz clock; user inputs change on falling edges
`timescale 1ns/1ps
module testbench;
	logic        i_clock;
	logic        i_arst_n;
	logic        i_req;
	logic        i_we;
	logic [15:0] i_addr;
	logic [3:0]  i_lane_en;
	logic [31:0] i_wdata;
	logic [31:0] o_rdata;
	logic        o_ready;
	logic        o_rvalid;
	int          bad_count;
	int          checked;
	int          cyc;
	psm_link_if link ();
	psm_host psm_host_i (.i_clock(i_clock), .i_arst_n(i_arst_n),
		.i_req(i_req), .i_we(i_we), .i_addr(i_addr), .i_lane_en(i_lane_en),
		.i_wdata(i_wdata), .o_ready(o_ready), .o_rvalid(o_rvalid),
		.o_rdata(o_rdata), .link(link));
	psm_memory psm_memory_i (.i_clock(i_clock), .i_arst_n(i_arst_n),
		.link(link));
	psm_monitor psm_monitor_i (.i_clock(i_clock), .i_arst_n(i_arst_n),
		.i_rd_n(link.rd_n), .i_wr_n(link.wr_n), .i_rdata(link.rdata),
		.i_init_n(link.init_n));
	////////////////////////////////////////////////////////////////////////
	task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
		checked++;
		if (e !== g) begin
			bad_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic go(logic w, logic [15:0] a, logic [3:0] l,
		logic [31:0] d);
		@(negedge i_clock);
		{i_req, i_we, i_addr, i_lane_en, i_wdata} = {1'b1, w, a, l, d};
	endtask
	task automatic idle(int n);
		repeat (n) @(negedge i_clock) i_req = 1'b0;
	endtask
	// the valid pulse stands one cycle: look at it mid-cycle
	task automatic get(logic [31:0] e);
		@(negedge i_clock);
		cmp("rvalid", 32'h1, {31'h0, o_rvalid});
		cmp("rdata", e, o_rdata);
	endtask
	// read with junk lanes and data; valid shows 3 edges after the take
	task automatic rd(logic [15:0] a, logic [31:0] e);
		go(1'b0, a, 4'hf, 32'hffffffff);
		idle(3);
		get(e);
	endtask
	////////////////////////////////////////////////////////////////////////
	// ready must rise exactly after clock lead-in, init pulse and wait
	task automatic t_start();
		int n = 0;
		int exp_n = psm_pkg::CLK_PRE_CYC + psm_pkg::INIT_HOLD_CYC +
			psm_pkg::START_WAIT_CYC;
		while (o_ready !== 1'b1 && n < 400) begin
			@(negedge i_clock);
			n++;
		end
		cmp("ready", 32'h1, {31'h0, o_ready});
		cmp("start cycles", 32'(exp_n), 32'(n));
		$display("test start done");
	endtask
	task automatic t_lanes();
		go(1'b1, 16'h1234, 4'hf, 32'h11223344);
		go(1'b1, 16'h1234, 4'h5, 32'haabbccdd);
		go(1'b1, 16'h1234, 4'ha, 32'h55667788);
		go(1'b1, 16'hffff, 4'hf, 32'h0badf00d);
		idle(3);
		rd(16'h1234, 32'h55bb77dd);
		rd(16'hffff, 32'h0badf00d);
		$display("test lanes done");
	endtask
	task automatic t_b2b();
		go(1'b0, 16'hffff, 4'hf, 32'h0);
		go(1'b0, 16'h1234, 4'h0, 32'h0);
		idle(2);
		get(32'h0badf00d);
		get(32'h55bb77dd);
		$display("test back to back done");
	endtask
	// write then read of one word on consecutive edges sees new data
	task automatic t_mix();
		go(1'b1, 16'h0001, 4'hf, 32'h12345678);
		go(1'b0, 16'h0001, 4'h0, 32'h0);
		idle(3);
		get(32'h12345678);
		$display("test mix done");
	endtask
	// second reset mid-run: control restarts, stored words survive
	task automatic t_keep();
		@(negedge i_clock) i_arst_n = 1'b0;
		idle(6);
		i_arst_n = 1'b1;
		t_start();
		rd(16'h1234, 32'h55bb77dd);
		$display("test keep done");
	endtask
	task automatic end_of_test();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	// hang guard, well above the roughly 330 cycles needed
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 2000) begin
			bad_count++;
			end_of_test();
		end
	end
	initial begin
		{i_arst_n, i_req, i_we, i_addr, i_lane_en, i_wdata} = '0;
		repeat (6) @(negedge i_clock);
		i_arst_n = 1'b1;
		t_start();
		t_lanes();
		t_b2b();
		t_mix();
		t_keep();
		end_of_test();
	end
endmodule
